/* File: wdt_timer.sv */
// watchdog timer: 16-bit up counter, prewarning then reset request
`timescale 1ns/1ps
`include "wdt_map.svh"
// What this block does
// RQ1 - comes up enabled after every reset
// RQ2 - disable and enable instructions stop, restart it
// RQ3 - software services before overflow while enabled
// RQ4 - overflow gives prewarning, then reset request
// RQ5 - 16-bit counter, tick divides by 16384/256
// RQ6 - counter loads from programmable reload field
// RQ7 - service reloads counter and clears prescaler
// RQ8 - default settings give 6.5 ms at 10 MHz
// RQ9 - counts up, overflow on wrap past all-ones
module wdt_timer (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wdt_pkg::wdt_cmd_type cmd,
  input wdt_pkg::wdt_cfg_type cfg,
  output logic enabled_r,
  output logic [`WDT_CNT_W-1:0] count_r,
  output logic [`WDT_REL_W-1:0] reload_r,
  output logic sel_fast_r,
  output logic prewarn_irq_r,
  output logic reset_req_r
);
  wdt_pkg::wdt_state_type state_r;
  wdt_pkg::wdt_state_type state_nxt;
  logic enabled_nxt;
  logic [`WDT_CNT_W-1:0] count_nxt;
  logic [`WDT_REL_W-1:0] reload_nxt;
  logic sel_fast_nxt;
  logic prewarn_nxt;
  logic reset_req_nxt;
  logic tick;
  logic [`WDT_PRE_W-1:0] pre_cnt;
  logic pre_run;
  logic pre_clr;
  logic svc_ok;
  logic wrap;
  logic [`WDT_CNT_W-1:0] reload_word;

  // once a reset request is out nothing but rstn takes it back
  assign svc_ok = cmd.service && (state_r != wdt_pkg::WDT_TRIP);
  assign pre_run = enabled_r && (state_r != wdt_pkg::WDT_TRIP);
  assign pre_clr = svc_ok; // RQ7
  assign wrap = pre_run && tick && (count_r == `WDT_CNT_MAX); // RQ9
  assign reload_word = reload_r; // RQ6

  wdt_prescaler u_pre (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .run(pre_run),
    .clr(pre_clr),
    .sel_fast(sel_fast_r),
    .tick_r(tick),
    .cnt_r(pre_cnt)
  );

  always_comb begin
    reload_nxt = reload_r;
    sel_fast_nxt = sel_fast_r;
    if (cfg.wr) begin
      reload_nxt = cfg.reload_value_field; // RQ6
      sel_fast_nxt = cfg.sel_fast; // RQ5
    end
  end

  always_comb begin
    state_nxt = state_r;
    enabled_nxt = enabled_r;
    count_nxt = count_r;
    prewarn_nxt = 1'b0;
    reset_req_nxt = reset_req_r;
    if (state_r != wdt_pkg::WDT_TRIP) begin
      // disable wins when both strobes come together
      if (cmd.disable_watchdog_instruction) begin
        enabled_nxt = 1'b0; // RQ2
      end else if (cmd.enable_watchdog_instruction) begin
        enabled_nxt = 1'b1; // RQ2
      end
    end
    case (state_r)
      wdt_pkg::WDT_RUN: begin
        if (svc_ok) begin
          count_nxt = reload_word; // RQ7
        end else if (wrap) begin
          count_nxt = reload_word; // RQ9
          prewarn_nxt = 1'b1; // RQ4
          state_nxt = wdt_pkg::WDT_PREWARN;
        end else if (pre_run && tick) begin
          count_nxt = count_r + `WDT_CNT_W'(1); // RQ5
        end
      end
      wdt_pkg::WDT_PREWARN: begin
        // a late service still rescues the system during the prewarning period
        if (svc_ok) begin
          count_nxt = reload_word; // RQ7
          state_nxt = wdt_pkg::WDT_RUN;
        end else if (wrap) begin
          reset_req_nxt = 1'b1; // RQ4
          state_nxt = wdt_pkg::WDT_TRIP;
        end else if (pre_run && tick) begin
          count_nxt = count_r + `WDT_CNT_W'(1);
        end
      end
      wdt_pkg::WDT_TRIP: begin
        reset_req_nxt = 1'b1;
      end
      default: begin
        state_nxt = wdt_pkg::WDT_TRIP;
        reset_req_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= wdt_pkg::WDT_RUN;
      enabled_r <= 1'b1; // RQ1
      count_r <= `WDT_DEF_RELOAD; // RQ8
      reload_r <= `WDT_DEF_RELOAD; // RQ8
      sel_fast_r <= `WDT_DEF_SEL_FAST; // RQ8
      prewarn_irq_r <= 1'b0;
      reset_req_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      enabled_r <= enabled_nxt;
      count_r <= count_nxt;
      reload_r <= reload_nxt;
      sel_fast_r <= sel_fast_nxt;
      prewarn_irq_r <= prewarn_nxt;
      reset_req_r <= reset_req_nxt;
    end
  end

  // helper: marks the first clock after reset release
  logic seen_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  // default ticks to overflow times tick period, in ns at the 10 MHz reference
  localparam int DEF_TICKS = 65536 - int'(`WDT_DEF_RELOAD);
  localparam int DEF_CYC = DEF_TICKS * `WDT_DIV_FAST;
  localparam int DEF_NS = DEF_CYC * (1000000 / `WDT_REF_CLK_KHZ);

  a_reset_enabled: assert property (@(posedge mclk) disable iff (!rstn) // RQ1
    !seen_r |-> enabled_r && !reset_req_r && state_r == wdt_pkg::WDT_RUN)
    else $error("watchdog not running after reset");

  a_disable_stops: assert property (@(posedge mclk) disable iff (!rstn) // RQ2
    clk_en && cmd.disable_watchdog_instruction && state_r != wdt_pkg::WDT_TRIP
    |=> !enabled_r ##1 ($stable(count_r) || $past(cmd.service)))
    else $error("disable did not stop watchdog");

  a_enable_starts: assert property (@(posedge mclk) disable iff (!rstn) // RQ2
    clk_en && cmd.enable_watchdog_instruction && !cmd.disable_watchdog_instruction
    && state_r != wdt_pkg::WDT_TRIP |=> enabled_r)
    else $error("enable did not restart watchdog");

  a_overflow_prewarn: assert property (@(posedge mclk) disable iff (!rstn) // RQ4
    clk_en && wrap && !svc_ok && state_r == wdt_pkg::WDT_RUN
    |=> prewarn_irq_r && !reset_req_r && state_r == wdt_pkg::WDT_PREWARN)
    else $error("overflow gave no prewarning");

  a_prewarn_first: assert property (@(posedge mclk) disable iff (!rstn) // RQ4
    $rose(reset_req_r) |-> $past(state_r) == wdt_pkg::WDT_PREWARN)
    else $error("reset request without prewarning");

  a_count_tick: assert property (@(posedge mclk) disable iff (!rstn) // RQ5
    clk_en && pre_run && tick && !svc_ok && count_r != `WDT_CNT_MAX
    |=> count_r == $past(count_r) + `WDT_CNT_W'(1))
    else $error("counter did not advance on tick");

  a_tick_spacing: assert property (@(posedge mclk) disable iff (!rstn) // RQ5
    tick && $past(clk_en) && $past(sel_fast_r)
    |-> $past(pre_cnt[7:0]) == 8'(`WDT_DIV_FAST - 1))
    else $error("fast tick off the 256 boundary");

  a_slow_spacing: assert property (@(posedge mclk) disable iff (!rstn) // RQ5
    tick && $past(clk_en) && !$past(sel_fast_r) |-> $past(pre_cnt) == `WDT_PRE_W'(`WDT_DIV_SLOW - 1))
    else $error("slow tick off the 16384 boundary");

  a_trip_sticky: assert property (@(posedge mclk) disable iff (!rstn) // RQ4
    reset_req_r |=> reset_req_r)
    else $error("reset request dropped before reset");

  a_prewarn_pulse: assert property (@(posedge mclk) disable iff (!rstn) // RQ4
    clk_en && prewarn_irq_r |=> !prewarn_irq_r)
    else $error("prewarning longer than one cycle");

  a_cfg_store: assert property (@(posedge mclk) disable iff (!rstn) // RQ6
    clk_en && cfg.wr |=> reload_r == $past(cfg.reload_value_field))
    else $error("reload field not stored");

  a_svc_reload: assert property (@(posedge mclk) disable iff (!rstn) // RQ7
    clk_en && svc_ok |=> count_r == $past(reload_r) && pre_cnt == '0)
    else $error("service did not reload and clear prescaler");

  a_default_cfg: assert property (@(posedge mclk) disable iff (!rstn) // RQ8
    !seen_r |-> reload_r == `WDT_DEF_RELOAD && sel_fast_r == `WDT_DEF_SEL_FAST
    && DEF_NS >= `WDT_DEF_INTERVAL_NS)
    else $error("default interval settings wrong");

  a_wrap_reload: assert property (@(posedge mclk) disable iff (!rstn) // RQ9
    clk_en && wrap && !svc_ok && state_r == wdt_pkg::WDT_RUN
    |=> count_r == $past(reload_r))
    else $error("wrap did not reload counter");

  c_service: cover property (@(posedge mclk) disable iff (!rstn)
    clk_en && svc_ok && state_r == wdt_pkg::WDT_RUN);
  c_prewarn: cover property (@(posedge mclk) disable iff (!rstn) $rose(prewarn_irq_r));
  c_trip: cover property (@(posedge mclk) disable iff (!rstn) $rose(reset_req_r));
  c_rescue: cover property (@(posedge mclk) disable iff (!rstn)
    clk_en && svc_ok && state_r == wdt_pkg::WDT_PREWARN);
  c_slow_tick: cover property (@(posedge mclk) disable iff (!rstn)
    tick && !sel_fast_r);
endmodule

/* File: wdt_map.svh */
// field widths, reset values and timing figures of the watchdog
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_CNT_W 16
`define WDT_REL_W 16
`define WDT_PRE_W 14
`define WDT_DIV_SLOW 16384
`define WDT_DIV_FAST 256
`define WDT_CNT_MAX 16'hffff
`define WDT_DEF_RELOAD 16'hff00
`define WDT_DEF_SEL_FAST 1'b1
`define WDT_REF_CLK_KHZ 10000
`define WDT_DEF_INTERVAL_NS 6500000
`define WDT_MCLK_PERIOD_NS 25
`endif

/* File: wdt_pkg.sv */
// types shared by the watchdog design files
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_RUN = 2'b00,
    WDT_PREWARN = 2'b01,
    WDT_TRIP = 2'b10
  } wdt_state_type;

  // one-cycle strobes from the core's instruction decoder
  typedef struct packed {
    logic service;
    logic disable_watchdog_instruction;
    logic enable_watchdog_instruction;
  } wdt_cmd_type;

  // configuration write: prescaler select (1 = divide by 256) and reload word
  // a full 16-bit reload lets the interval shrink to a single tick
  typedef struct packed {
    logic wr;
    logic sel_fast;
    logic [15:0] reload_value_field;
  } wdt_cfg_type;
endpackage

/* File: wdt_prescaler.sv */
// prescaler dividing the system clock by 16384 or 256
`timescale 1ns/1ps
`include "wdt_map.svh"
module wdt_prescaler (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic run,
  input wire logic clr,
  input wire logic sel_fast,
  output logic tick_r,
  output logic [`WDT_PRE_W-1:0] cnt_r
);
  localparam logic [`WDT_PRE_W-1:0] TERM_SLOW = `WDT_PRE_W'(`WDT_DIV_SLOW - 1);
  localparam logic [`WDT_PRE_W-1:0] TERM_FAST = `WDT_PRE_W'(`WDT_DIV_FAST - 1);

  logic [`WDT_PRE_W-1:0] cnt_nxt;
  logic tick_nxt;
  logic term;

  always_comb begin
    term = sel_fast ? (cnt_r[7:0] == TERM_FAST[7:0]) : (cnt_r == TERM_SLOW); // RQ5
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (clr) begin
      cnt_nxt = '0; // RQ7
    end else if (run) begin
      if (term) begin
        cnt_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + `WDT_PRE_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

/* File: wdt_core_model.sv */
// processor core model issuing watchdog instructions as decoder strobes
`timescale 1ns/1ps
module wdt_core_model (
  input wire logic mclk,
  output wdt_pkg::wdt_cmd_type cmd
);
  initial cmd = '0;
  // k = {service, disable, enable}; a strobe lasts exactly one cycle
  task automatic instr(input logic [2:0] k);
    @(posedge mclk);
    #1 cmd = k;
    @(posedge mclk);
    #1 cmd = '0;
  endtask
endmodule

/* File: tb_watchdog_timer_unit.sv */
// self-checking bench for the watchdog timer
`timescale 1ns/1ps
`include "wdt_map.svh"
`define CHK(n, e, g) chk(n, 16'(e), 16'(g))
module tb_watchdog_timer_unit;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  wdt_pkg::wdt_cmd_type cmd;
  wdt_pkg::wdt_cfg_type cfg = '0;
  logic enabled_r, sel_fast_r, prewarn_irq_r, reset_req_r;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic [15:0] c0;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  initial forever #12.5 mclk = ~mclk;
  wdt_core_model core (.mclk(mclk), .cmd(cmd));
  wdt_timer dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .cmd(cmd), .cfg(cfg),
    .enabled_r(enabled_r), .count_r(count_r), .reload_r(reload_r),
    .sel_fast_r(sel_fast_r), .prewarn_irq_r(prewarn_irq_r), .reset_req_r(reset_req_r));
  task automatic step(input int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // the slow tick and two short overflow intervals dominate the run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end
  task automatic cfg_wr(input logic [15:0] rel, input logic sel);
    cfg = '{wr: 1'b1, sel_fast: sel, reload_value_field: rel};
    step();
    cfg.wr = 1'b0;
    step();
  endtask
  task automatic t_reset();
    `CHK("enabled", 8'h1, enabled_r);
    `CHK("count", 16'hff00, count_r);
    `CHK("reload", 16'hff00, reload_r);
    `CHK("sel_fast", 8'h1, sel_fast_r);
    `CHK("irq", 8'h0, prewarn_irq_r);
    `CHK("rst_req", 8'h0, reset_req_r);
  endtask
  task automatic wait_change(input int lim);
    c0 = count_r;
    n = 0;
    while (count_r === c0 && n < lim) begin
      step();
      n++;
    end
  endtask
  task automatic t_tick();
    wait_change(400);
    wait_change(400);
    `CHK("tick_cycles", 16'h100, n);
    `CHK("count_up", c0 + 16'h1, count_r);
  endtask
  task automatic t_reload();
    cfg_wr(16'h8000, 1'b1);
    `CHK("reload_r", 16'h8000, reload_r);
    core.instr(3'b100);
    step();
    `CHK("svc_count", 16'h8000, count_r);
    step(250);
    `CHK("pre_clear", 16'h8000, count_r);
    step(10);
    `CHK("first_tick", 16'h8001, count_r);
  endtask
  // service clears the prescaler, the registered tick adds one cycle
  task automatic t_slow();
    cfg_wr(16'h8000, 1'b0);
    `CHK("sel_slow", 8'h0, sel_fast_r);
    core.instr(3'b100);
    wait_change(20000);
    `CHK("slow_cycles", `WDT_DIV_SLOW + 1, n);
    `CHK("slow_up", 16'h8001, count_r);
    cfg_wr(16'h8000, 1'b1);
    `CHK("sel_back", 8'h1, sel_fast_r);
  endtask
  task automatic t_onoff();
    core.instr(3'b010);
    step();
    `CHK("disabled", 8'h0, enabled_r);
    c0 = count_r;
    step(600);
    `CHK("held", c0, count_r);
    core.instr(3'b001);
    step();
    `CHK("reenabled", 8'h1, enabled_r);
    clk_en = 1'b0;
    c0 = count_r;
    step(600);
    `CHK("frozen", c0, count_r);
    clk_en = 1'b1;
    core.instr(3'b011);
    step();
    `CHK("dis_wins", 8'h0, enabled_r);
    core.instr(3'b001);
  endtask
  task automatic wait_flag(input bit rst_flag);
    n = 0;
    while ((rst_flag ? reset_req_r : prewarn_irq_r) !== 1'b1 && n < 10000) begin
      step();
      n++;
    end
  endtask
  task automatic t_overflow();
    cfg_wr(16'hfff0, 1'b1);
    core.instr(3'b100);
    wait_flag(1'b0);
    // 16 ticks of 256 cycles, plus one for the registered tick
    `CHK("pw_interval", 16'h1001, n);
    `CHK("no_rst_yet", 8'h0, reset_req_r);
    step();
    `CHK("pw_pulse", 8'h0, prewarn_irq_r);
    wait_flag(1'b1);
    // the second interval runs from the prewarning; one cycle went to the pulse check
    `CHK("rst_interval", 16'hfff, n);
    core.instr(3'b100);
    step(3);
    `CHK("trip_sticky", 8'h1, reset_req_r);
    rstn = 1'b0;
    step();
    rstn = 1'b1;
    step();
    t_reset();
  endtask
  initial begin
    step(2);
    rstn = 1'b1;
    step();
    t_reset();
    t_tick();
    t_reload();
    t_slow();
    t_onoff();
    t_overflow();
    final_report();
  end
endmodule
